// >>> rom_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behavioural boot ROM or flash plus a one-bit serial configuration ROM
module rom_partner
(
    input  wire logic        clk_i,
    input  wire logic [17:0] rom_addr_i,
    input  wire logic [7:0]  rom_data_o_i,
    input  wire logic        rom_data_oe_n_i,
    input  wire logic        rom_cs_n_i,
    input  wire logic        rom_rd_n_i,
    input  wire logic        rom_wr_n_i,
    input  wire logic        sr_cs_i,
    input  wire logic        sr_clk_i,
    input  wire logic        sr_di_i,
    output logic [7:0]       rom_data_o,
    output logic             sr_do_o
);
    // Cells hold the difference to the blank pattern, so an unwritten cell reads the pattern
    bit   [7:0] mem [0:262143];
    logic [7:0] last_q = 8'h00;
    logic [7:0] val;
    logic       bit_q = 1'b0;

    // Content of a cell that was never programmed
    function automatic logic [7:0] blank(input logic [17:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    // Drive the byte only while read-selected, a changed pattern otherwise
    always_comb
    begin
        val = mem[rom_addr_i] ^ blank(rom_addr_i);
        rom_data_o = (!rom_cs_n_i && !rom_rd_n_i) ? val : ~last_q;
    end

    // Remember the last driven byte and store program cycles
    always @(posedge clk_i)
    begin
        if (!rom_cs_n_i && !rom_rd_n_i)
            last_q <= val;
        if (!rom_cs_n_i && !rom_wr_n_i && !rom_data_oe_n_i)
            mem[rom_addr_i] <= rom_data_o_i ^ blank(rom_addr_i);
    end

    // Serial ROM echoes the bit taken at the last selected rising clock while selected, its inverse while deselected
    always @(posedge sr_clk_i)
    begin
        if (sr_cs_i)
            bit_q <= sr_di_i;
    end
    assign sr_do_o = sr_cs_i ? bit_q : ~bit_q;
endmodule // rom_partner

// >>> rom_tally_pkg.sv
package rom_tally_pkg;

    // Register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] TALLY_OFS      = 8'h00;
    localparam logic [7:0] ROM_CTRL_OFS   = 8'h04;
    localparam logic [7:0] ROM_PTR_OFS    = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS   = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h10;

    // Dropped-frame tally layout
    localparam int         TALLY_OVF_BIT  = 16;
    localparam logic [31:0] TALLY_RESET   = 32'hfffe0000;

    // ROM interface control layout
    localparam int         STRAP_BIT      = 15;
    localparam int         FETCH_BIT      = 14;
    localparam int         PROGRAM_BIT    = 13;
    localparam int         PAR_SEL_BIT    = 12;
    localparam int         SER_SEL_BIT    = 11;
    localparam int         EXT_SEL_BIT    = 10;
    localparam int         SER_DOUT_BIT   = 3;
    localparam int         SER_DIN_BIT    = 2;
    localparam int         SER_CLK_BIT    = 1;
    localparam int         SER_CS_BIT     = 0;
    localparam logic [31:0] ROM_CTRL_RESET = 32'hffff03ff;
    localparam logic [17:0] ROM_PTR_RESET = 18'h00000;

    // Interrupt status layout
    localparam int         IRQ_DROP_BIT   = 0;
    localparam int         IRQ_OVF_BIT    = 1;
    localparam int         IRQ_DONE_BIT   = 2;
    localparam int         IRQ_W          = 3;

    // Parallel ROM strobe timing
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         ROM_STROBE_NS  = 120;
    localparam logic [7:0] ROM_STROBE_CYCLES =
        8'((ROM_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {ROM_IDLE, ROM_FETCH, ROM_PROGRAM} rom_phase_type;

endpackage

// >>> rom_tally_regs.sv
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rom_tally_regs
    import rom_tally_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             irq_o,
    input  wire logic        frame_drop_i,
    input  wire logic        mode_strap_i,
    output logic             op_mode_o,
    output logic [17:0]      rom_addr_o,
    input  wire logic [7:0]  rom_data_i,
    output logic [7:0]       rom_data_o,
    output logic             rom_data_oe_n_o,
    output logic             rom_cs_n_o,
    output logic             rom_rd_n_o,
    output logic             rom_wr_n_o,
    output logic             ext_reg_sel_o,
    output logic             sr_cs_o,
    output logic             sr_clk_o,
    output logic             sr_di_o,
    input  wire logic        sr_do_i
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic             ack;
        logic [31:0]      dat;
        logic [15:0]      cnt;
        logic             ovf;
        logic             strap;
        logic             fetch;
        logic             prog;
        logic             par_sel;
        logic             ser_sel;
        logic             ext_sel;
        logic [7:0]       data;
        logic [17:0]      ptr;
        logic [IRQ_W-1:0] stat;
        logic [IRQ_W-1:0] mask;
        logic             irq;
        rom_phase_type    phase;
        logic [7:0]       strobe;
        logic [2:0]       strap_sync;
        logic [2:0]       sdo_sync;
        logic [7:0]       rd_sync0;
        logic [7:0]       rd_sync1;
        logic [7:0]       rd_sync2;
        logic             sdo;
        logic             mode;
        logic             cs_n;
        logic             rd_n;
        logic             wr_n;
        logic             oe_n;
        logic             sr_cs;
        logic             sr_clk;
        logic             sr_di;
    } state_type;

    state_type state_r;
    state_type state_nxt;

    // Byte-lane merge of write data into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  lanes);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (lanes[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Serial port is live only when selected with fetch or program
    function automatic logic ser_live(input state_type s);
        return s.ser_sel & (s.fetch | s.prog);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic        req;
    logic        rd_tally;
    logic        wr_ctrl;
    logic [31:0] tally_word;
    logic [31:0] ctrl_word;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic        wrap;

    // A request is taken in the cycle before ack rises
    assign req      = cyc_i & stb_i & ~state_r.ack;
    assign rd_tally = req & ~we_i & (adr_i == TALLY_OFS);
    assign wr_ctrl  = req & we_i & (adr_i == ROM_CTRL_OFS);
    assign wrap     = frame_drop_i & (state_r.cnt == 16'hffff);

    // Current register images
    always_comb
    begin
        tally_word = {TALLY_RESET[31:17], state_r.ovf, state_r.cnt};
        ctrl_word  = {ROM_CTRL_RESET[31:16], state_r.strap, state_r.fetch, state_r.prog,
                      state_r.par_sel, state_r.ser_sel, state_r.ext_sel,
                      ROM_CTRL_RESET[9:8], state_r.data};
        if (ser_live(state_r))
        begin
            ctrl_word[SER_DOUT_BIT] = state_r.sdo;
        end
        unique case (adr_i)
            TALLY_OFS:    rd_word = tally_word;
            ROM_CTRL_OFS: rd_word = ctrl_word;
            ROM_PTR_OFS:  rd_word = {14'h0000, state_r.ptr};
            IRQ_STAT_OFS: rd_word = {29'h00000000, state_r.stat};
            IRQ_MASK_OFS: rd_word = {29'h00000000, state_r.mask};
            default:      rd_word = 32'h00000000;
        endcase
        wr_word = lane_merge(rd_word, dat_i, sel_i);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        state_nxt = state_r;

        // Wishbone answer one cycle after the request is taken
        state_nxt.ack = req;
        state_nxt.dat = req & ~we_i ? rd_word : 32'h00000000;

        // Pin synchronisers: three stages; strap and serial-data change counts when last two agree, ROM data is used from the last stage
        state_nxt.strap_sync = {state_r.strap_sync[1:0], mode_strap_i};
        state_nxt.sdo_sync   = {state_r.sdo_sync[1:0], sr_do_i};
        state_nxt.rd_sync0   = rom_data_i;
        state_nxt.rd_sync1   = state_r.rd_sync0;
        state_nxt.rd_sync2   = state_r.rd_sync1;
        if (state_r.strap_sync[1] == state_r.strap_sync[2])
        begin
            state_nxt.strap = ~state_r.strap_sync[2];
        end
        if (state_r.sdo_sync[1] == state_r.sdo_sync[2])
        begin
            state_nxt.sdo = state_r.sdo_sync[2];
        end

        // Dropped-frame tally with read-to-clear; a new drop is never lost
        if (rd_tally)
        begin
            state_nxt.cnt = {15'h0000, frame_drop_i};
            state_nxt.ovf = wrap;
        end
        else if (frame_drop_i)
        begin
            state_nxt.cnt = 16'(state_r.cnt + 16'h0001);
            state_nxt.ovf = state_r.ovf | wrap;
        end

        // Register writes
        if (req & we_i)
        begin
            unique case (adr_i)
                ROM_CTRL_OFS:
                begin
                    // Strap status bit is not writable
                    state_nxt.fetch   = wr_word[FETCH_BIT];
                    state_nxt.prog    = wr_word[PROGRAM_BIT];
                    state_nxt.par_sel = wr_word[PAR_SEL_BIT];
                    state_nxt.ser_sel = wr_word[SER_SEL_BIT];
                    state_nxt.ext_sel = wr_word[EXT_SEL_BIT];
                    state_nxt.data    = wr_word[7:0];
                end
                ROM_PTR_OFS:  state_nxt.ptr  = wr_word[17:0];
                IRQ_MASK_OFS: state_nxt.mask = wr_word[IRQ_W-1:0];
                IRQ_STAT_OFS: state_nxt.stat = state_r.stat & ~wr_word[IRQ_W-1:0];
                default:      state_nxt.ptr  = state_r.ptr;
            endcase
        end

        // Parallel ROM cycle sequencer
        unique case (state_r.phase)
            ROM_IDLE:
            begin
                if (wr_ctrl & wr_word[PAR_SEL_BIT] & wr_word[FETCH_BIT])
                begin
                    state_nxt.phase  = ROM_FETCH;
                    state_nxt.strobe = ROM_STROBE_CYCLES;
                end
                else if (wr_ctrl & wr_word[PAR_SEL_BIT] & wr_word[PROGRAM_BIT])
                begin
                    state_nxt.phase  = ROM_PROGRAM;
                    state_nxt.strobe = ROM_STROBE_CYCLES;
                end
            end
            ROM_FETCH, ROM_PROGRAM:
            begin
                state_nxt.strobe = 8'(state_r.strobe - 8'h01);
                if (state_r.strobe == 8'h01)
                begin
                    state_nxt.phase = ROM_IDLE;
                    if (state_r.phase == ROM_FETCH)
                    begin
                        state_nxt.data = state_r.rd_sync2;
                    end
                end
            end
            default: state_nxt.phase = ROM_IDLE;
        endcase

        // Interrupt status: set wins over a clear in the same cycle
        if (frame_drop_i)
        begin
            state_nxt.stat[IRQ_DROP_BIT] = 1'b1;
        end
        if (wrap)
        begin
            state_nxt.stat[IRQ_OVF_BIT] = 1'b1;
        end
        if (state_r.phase != ROM_IDLE && state_r.strobe == 8'h01)
        begin
            state_nxt.stat[IRQ_DONE_BIT] = 1'b1;
        end
        state_nxt.irq = |(state_nxt.stat & state_nxt.mask);

        // Pin outputs, registered from the next state
        state_nxt.mode = ~state_nxt.strap;
        state_nxt.cs_n = state_nxt.phase == ROM_IDLE;
        state_nxt.rd_n = state_nxt.phase != ROM_FETCH;
        state_nxt.wr_n = state_nxt.phase != ROM_PROGRAM;
        state_nxt.oe_n = state_nxt.phase != ROM_PROGRAM;
        // Serial pins follow the data field only while selected with fetch or program
        state_nxt.sr_cs  = ser_live(state_nxt) & state_nxt.data[SER_CS_BIT];
        state_nxt.sr_clk = ser_live(state_nxt) & state_nxt.data[SER_CLK_BIT];
        state_nxt.sr_di  = ser_live(state_nxt) & state_nxt.data[SER_DIN_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r            <= '0;
            state_r.cnt        <= TALLY_RESET[15:0];
            state_r.ovf        <= TALLY_RESET[TALLY_OVF_BIT];
            state_r.strap      <= ROM_CTRL_RESET[STRAP_BIT];
            // Synchroniser and mode start at the level the status bit implies
            state_r.strap_sync <= {3{~ROM_CTRL_RESET[STRAP_BIT]}};
            state_r.mode       <= ~ROM_CTRL_RESET[STRAP_BIT];
            state_r.data       <= ROM_CTRL_RESET[7:0];
            state_r.ptr        <= ROM_PTR_RESET;
            state_r.phase      <= ROM_IDLE;
            state_r.cs_n       <= 1'b1;
            state_r.rd_n       <= 1'b1;
            state_r.wr_n       <= 1'b1;
            state_r.oe_n       <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state register
    assign dat_o           = state_r.dat;
    assign ack_o           = state_r.ack;
    assign irq_o           = state_r.irq;
    assign op_mode_o       = state_r.mode;
    assign rom_addr_o      = state_r.ptr;
    assign rom_data_o      = state_r.data;
    assign rom_data_oe_n_o = state_r.oe_n;
    assign rom_cs_n_o      = state_r.cs_n;
    assign rom_rd_n_o      = state_r.rd_n;
    assign rom_wr_n_o      = state_r.wr_n;
    assign ext_reg_sel_o   = state_r.ext_sel;
    assign sr_cs_o         = state_r.sr_cs;
    assign sr_clk_o        = state_r.sr_clk;
    assign sr_di_o         = state_r.sr_di;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    tally_incr_a: assert property (frame_drop_i && !rd_tally && state_r.cnt != 16'hffff
        |=> state_r.cnt == 16'($past(state_r.cnt) + 16'h0001))
        else $error("tally did not count a dropped frame");
    tally_clear_a: assert property (rd_tally && !frame_drop_i
        |=> state_r.cnt == 16'h0000 && ack_o && dat_o[15:0] == $past(state_r.cnt))
        else $error("tally read did not return then clear");
    ovf_set_a: assert property (wrap && !rd_tally |=> state_r.ovf && state_r.cnt == 16'h0000)
        else $error("overflow not flagged on wrap");
    ovf_clear_a: assert property (rd_tally && !wrap |=> !state_r.ovf)
        else $error("overflow not cleared by read");
    strap_bit_a: assert property (state_r.strap_sync[1] == state_r.strap_sync[2]
        |=> state_r.strap == !$past(state_r.strap_sync[2]))
        else $error("strap status does not follow pin");
    mode_out_a: assert property (##1 op_mode_o == !$past(state_nxt.strap))
        else $error("operating mode disagrees with strap");
    strap_wr_a: assert property (wr_ctrl && state_r.strap_sync[1] != state_r.strap_sync[2]
        |=> $stable(state_r.strap))
        else $error("write changed strap status");
    fetch_cyc_a: assert property (wr_ctrl && state_r.phase == ROM_IDLE
        && wr_word[PAR_SEL_BIT] && wr_word[FETCH_BIT]
        |=> !rom_rd_n_o && !rom_cs_n_o && rom_wr_n_o)
        else $error("fetch cycle not started");
    prog_cyc_a: assert property (wr_ctrl && state_r.phase == ROM_IDLE && wr_word[PAR_SEL_BIT]
        && !wr_word[FETCH_BIT] && wr_word[PROGRAM_BIT]
        |=> !rom_wr_n_o && !rom_data_oe_n_o && rom_rd_n_o)
        else $error("program cycle not started");
    ser_idle_a: assert property (!ser_live(state_r) |-> !sr_cs_o && !sr_clk_o)
        else $error("serial pins active while unselected");

    fetch_cover: cover property (state_r.phase == ROM_FETCH ##1 state_r.phase == ROM_IDLE);
    prog_cover:  cover property (state_r.phase == ROM_PROGRAM ##1 state_r.phase == ROM_IDLE);
    wrap_cover:  cover property (wrap ##[1:20] rd_tally);
    ser_cover:   cover property (sr_cs_o ##1 sr_clk_o);

endmodule // rom_tally_regs

// >>> rom_tally_regs_bench.sv
`timescale 1ns/1ps
module rom_tally_regs_bench
    import rom_tally_pkg::*;
;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, frame_drop_i;
    logic        mode_strap_i, op_mode_o, rom_data_oe_n_o, rom_cs_n_o, rom_rd_n_o;
    logic        rom_wr_n_o, ext_reg_sel_o, sr_cs_o, sr_clk_o, sr_di_o, sr_do_i, b;
    logic [7:0]  adr_i, rom_data_i, rom_data_o, byt;
    logic [3:0]  sel_i, lanes;
    logic [17:0] rom_addr_o, ptr;
    logic [31:0] dat_i, dat_o, rd, w;
    int          errors, num_checks, n;

    rom_tally_regs dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .irq_o, .frame_drop_i, .mode_strap_i, .op_mode_o, .rom_addr_o,
        .rom_data_i, .rom_data_o, .rom_data_oe_n_o, .rom_cs_n_o, .rom_rd_n_o,
        .rom_wr_n_o, .ext_reg_sel_o, .sr_cs_o, .sr_clk_o, .sr_di_o, .sr_do_i);
    rom_partner far (.clk_i, .rom_addr_i(rom_addr_o), .rom_data_o_i(rom_data_o),
        .rom_data_oe_n_i(rom_data_oe_n_o), .rom_cs_n_i(rom_cs_n_o), .rom_rd_n_i(rom_rd_n_o),
        .rom_wr_n_i(rom_wr_n_o), .sr_cs_i(sr_cs_o), .sr_clk_i(sr_clk_o),
        .sr_di_i(sr_di_o), .rom_data_o(rom_data_i), .sr_do_o(sr_do_i));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (100000) @(posedge clk_i);
        errors++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare tasks and expectations
    task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check1(input string what, input logic exp, input logic got);
        check32(what, {31'h0, exp}, {31'h0, got});
    endtask
    function automatic logic [31:0] ctrl_exp(input logic [31:0] v, input logic strap);
        return {16'hffff, ~strap, v[14:10], 2'b11, v[7:0]};
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone classic single cycle, waits for ack; only the watchdog ends a hang
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= wr; adr_i <= a; dat_i <= d; sel_i <= lanes;
        k = 0;
        do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        check32("ack wait", 32'd2, k);
    endtask
    task automatic rd_expect(input string what, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check32(what, e, rd);
    endtask
    task automatic drop(input int cnt);
        repeat (cnt) begin @(posedge clk_i); frame_drop_i <= 1'b1; end
        @(posedge clk_i); frame_drop_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        do begin wb(1'b0, IRQ_STAT_OFS, 32'h0); k++; end while (rd[2] !== 1'b1 && k < 40);
        check1("rom done", 1'b1, rd[IRQ_DONE_BIT]);
        wb(1'b1, IRQ_STAT_OFS, 32'h4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00;
        sel_i = 4'hf; dat_i = 32'h0; frame_drop_i = 1'b0; mode_strap_i = 1'b1;
        lanes = 4'hf;
        errors = 0; num_checks = 0;
        void'($urandom(21));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rd_expect("tally reset", TALLY_OFS, TALLY_RESET);
        rd_expect("ctrl reset", ROM_CTRL_OFS, ROM_CTRL_RESET);
        check1("op mode 1", 1'b1, op_mode_o);
        wb(1'b1, ROM_CTRL_OFS, 32'h8000);
        rd_expect("ctrl bit15 write", ROM_CTRL_OFS, 32'hffff0300);
        mode_strap_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rd_expect("ctrl strap low", ROM_CTRL_OFS, 32'hffff8300);
        check1("op mode 0", 1'b0, op_mode_o);
        // Random drop burst, read-to-clear, and interrupt mask and clear
        n = 1 + $urandom % 20;
        drop(n);
        check1("irq masked", 1'b0, irq_o);
        rd_expect("tally count", TALLY_OFS, TALLY_RESET | n);
        rd_expect("tally cleared", TALLY_OFS, TALLY_RESET);
        wb(1'b1, IRQ_MASK_OFS, 32'h3);
        repeat (2) @(posedge clk_i);
        check1("irq raised", 1'b1, irq_o);
        wb(1'b1, IRQ_STAT_OFS, 32'h3);
        repeat (2) @(posedge clk_i);
        check1("irq cleared", 1'b0, irq_o);
        // Wrap of the count sets the sticky overflow, a read clears it
        drop(65537);
        rd_expect("tally wrap", TALLY_OFS, 32'hffff0001);
        rd_expect("tally ovf clear", TALLY_OFS, TALLY_RESET);
        wb(1'b0, IRQ_STAT_OFS, 32'h0);
        check32("irq stat", 32'h3, rd & 32'h7);
        wb(1'b1, IRQ_STAT_OFS, 32'h3);
        wb(1'b1, 8'h14, 32'hffffffff);
        rd_expect("unmapped", 8'h14, 32'h0);
        // Parallel fetch, program, then fetch of the programmed byte
        ptr = 18'($urandom);
        byt = 8'($urandom);
        // Only the low lane lands on the still-zero pointer
        lanes = 4'h1;
        wb(1'b1, ROM_PTR_OFS, {14'h0, ptr});
        lanes = 4'hf;
        rd_expect("pointer lane", ROM_PTR_OFS, {24'h0, ptr[7:0]});
        wb(1'b1, ROM_PTR_OFS, {14'h0, ptr});
        rd_expect("pointer", ROM_PTR_OFS, {14'h0, ptr});
        wb(1'b1, ROM_CTRL_OFS, 32'h5000);
        @(negedge clk_i);
        check32("rom addr", {14'h0, ptr}, {14'h0, rom_addr_o});
        check1("fetch cs", 1'b0, rom_cs_n_o);
        check1("fetch rd", 1'b0, rom_rd_n_o);
        wait_done();
        wb(1'b0, ROM_CTRL_OFS, 32'h0);
        check32("fetch byte", {24'h0, ptr[7:0] ^ ptr[15:8] ^ 8'h3c}, rd & 32'hff);
        wb(1'b1, ROM_CTRL_OFS, 32'h3000 | byt);
        @(negedge clk_i);
        check1("prog wr", 1'b0, rom_wr_n_o);
        check1("prog oe", 1'b0, rom_data_oe_n_o);
        check32("prog data", {24'h0, byt}, {24'h0, rom_data_o});
        wait_done();
        wb(1'b1, ROM_CTRL_OFS, 32'h5000);
        wait_done();
        wb(1'b0, ROM_CTRL_OFS, 32'h0);
        check32("refetch byte", {24'h0, byt}, rd & 32'hff);
        // Serial ROM bit-banging: data first, then the rising clock
        for (int i = 0; i < 8; i++)
        begin
            b = 1'($urandom);
            w = 32'h4801 | {29'h0, b, 2'b00};
            wb(1'b1, ROM_CTRL_OFS, w);
            wb(1'b1, ROM_CTRL_OFS, w | 32'h2);
            @(negedge clk_i);
            check1("sr cs", 1'b1, sr_cs_o);
            check1("sr clk", 1'b1, sr_clk_o);
            check1("sr di", b, sr_di_o);
            repeat (6) @(posedge clk_i);
            rd_expect("sr do", ROM_CTRL_OFS, ctrl_exp(w | 32'h2 | {b, 3'b000}, 1'b0));
        end
        wb(1'b1, ROM_CTRL_OFS, 32'h2807);
        @(negedge clk_i);
        check1("sr program cs", 1'b1, sr_cs_o);
        wb(1'b1, ROM_CTRL_OFS, 32'h0c07);
        @(negedge clk_i);
        check1("ext select", 1'b1, ext_reg_sel_o);
        check1("sr idle cs", 1'b0, sr_cs_o);
        check1("sr idle clk", 1'b0, sr_clk_o);
        check1("sr idle di", 1'b0, sr_di_o);
        rd_expect("ctrl ext", ROM_CTRL_OFS, ctrl_exp(32'h0c07, 1'b0));
        final_report();
    end
endmodule // rom_tally_regs_bench
